// File: shared/addr_filter_pkg.sv
// Register map, field positions and reset values of the address filter
package addr_filter_pkg;

  // Register offsets on the local register port
  localparam logic [7:0] SERIAL_CONTROL_OFS = 8'h98;
  localparam logic [7:0] OWN_ADDRESS_OFS = 8'hA9;
  localparam logic [7:0] ADDRESS_MASK_OFS = 8'hB9;
  localparam logic [7:0] FRAMING_CTRL_OFS = 8'hC1;

  // Field positions in serial_control
  localparam int unsigned MODE0_ERR_BIT = 7;
  localparam int unsigned MODE1_BIT = 6;
  localparam int unsigned MPEN_BIT = 5;
  localparam int unsigned REN_BIT = 4;
  localparam int unsigned TX9_BIT = 3;
  localparam int unsigned RX9_BIT = 2;
  localparam int unsigned TXDONE_BIT = 1;
  localparam int unsigned RXDONE_BIT = 0;

  // Field position in the framing control register
  localparam int unsigned FRAMING_SEL_BIT = 0;

  // Reset values
  localparam logic [7:0] ADDR_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] READ_IDLE = 8'h00;
  localparam logic [7:0] ALL_ONES = 8'hFF;

  // Serial modes as {mode_bit0, mode_bit1}
  localparam logic [1:0] MODE_SHIFT = 2'h0;
  localparam logic [1:0] MODE_UART8 = 2'h1;
  localparam logic [1:0] MODE_UART9_FIX = 2'h2;
  localparam logic [1:0] MODE_UART9_VAR = 2'h3;

  // Register width
  localparam int unsigned REG_W = 8;

endpackage

// File: design/uart_slave_address_filter.sv
// Receive address filter and serial control register of the serial port
`timescale 1ns/10ps
`default_nettype none

module uart_slave_address_filter (
  input wire logic clk_in,
  input wire logic nrst_in,
  // Register port
  input wire logic [addr_filter_pkg::REG_W-1:0] reg_addr_in,
  input wire logic [addr_filter_pkg::REG_W-1:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output logic [addr_filter_pkg::REG_W-1:0] reg_rdata_out,
  // Events from the receive and transmit frame engine
  input wire logic frame_valid_in,
  input wire logic [addr_filter_pkg::REG_W-1:0] frame_data_in,
  input wire logic frame_ninth_in,
  input wire logic frame_stop_ok_in,
  input wire logic framing_error_in,
  input wire logic tx_complete_in,
  // Control towards the frame engine
  output logic serial_mode_bit0_out,
  output logic serial_mode_bit1_out,
  output logic multiproc_enable_out,
  output logic rx_enable_out,
  output logic tx_ninth_bit_out,
  output logic framing_check_select_out,
  // Receive results and transmit done flag
  output logic rx_done_flag_out,
  output logic tx_done_flag_out,
  output logic framing_error_flag_out,
  output logic frame_accept_out,
  output logic [addr_filter_pkg::REG_W-1:0] rx_byte_out
);
  import addr_filter_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [REG_W-1:0] own_address_byte_q;
  logic [REG_W-1:0] address_mask_byte_q;
  logic serial_mode_bit0_q;
  logic serial_mode_bit1_q;
  logic multiproc_enable_q;
  logic rx_enable_q;
  logic tx_ninth_bit_q;
  logic rx_ninth_bit_q;
  logic tx_done_flag_q;
  logic rx_done_flag_q;
  logic framing_error_flag_q;
  logic framing_check_select_q;
  logic frame_accept_q;
  logic [REG_W-1:0] rx_byte_q;
  logic [REG_W-1:0] reg_rdata_q;
  logic [REG_W-1:0] reg_rdata_d;

  logic wr_control;
  logic wr_own;
  logic wr_mask;
  logic wr_framing;
  logic [1:0] mode;
  logic [REG_W-1:0] broadcast_pattern;
  logic [REG_W-1:0] given_bit_ok;
  logic [REG_W-1:0] bcast_bit_ok;
  logic given_match;
  logic bcast_match;
  logic address_match;
  logic address_frame;
  logic accept;
  logic serial_control_rd;

  //////////////////////////////////////////////////////////////////////////////
  // Write decode

  // One strobe at a time, so a plain address compare is enough
  assign wr_control = reg_write_in && (reg_addr_in == SERIAL_CONTROL_OFS);
  assign wr_own = reg_write_in && (reg_addr_in == OWN_ADDRESS_OFS);
  assign wr_mask = reg_write_in && (reg_addr_in == ADDRESS_MASK_OFS);
  assign wr_framing = reg_write_in && (reg_addr_in == FRAMING_CTRL_OFS);

  //////////////////////////////////////////////////////////////////////////////
  // Address registers

  // Own address byte, cleared by reset so the filter passes everything
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      own_address_byte_q <= ADDR_RESET;
    end else if (wr_own) begin
      own_address_byte_q <= reg_wdata_in;
    end
  end

  // Mask byte; a zero after reset makes every bit a don't-care
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      address_mask_byte_q <= MASK_RESET;
    end else if (wr_mask) begin
      address_mask_byte_q <= reg_wdata_in;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Address comparison

  // The broadcast pattern is never stored, so it follows both registers at once
  assign broadcast_pattern = own_address_byte_q | address_mask_byte_q;

  // Per-bit compare: a bit passes when it is masked off or when it agrees
  for (genvar b = 0; b < REG_W; b++) begin : g_bit
    assign given_bit_ok[b] = !address_mask_byte_q[b]
                             || (frame_data_in[b] == own_address_byte_q[b]);
    assign bcast_bit_ok[b] = !broadcast_pattern[b] || frame_data_in[b];
  end

  assign given_match = &given_bit_ok;
  assign bcast_match = &bcast_bit_ok;
  assign address_match = given_match || bcast_match;

  //////////////////////////////////////////////////////////////////////////////
  // Frame acceptance

  assign mode = {serial_mode_bit0_q, serial_mode_bit1_q};

  // What counts as an address frame depends on the mode
  always_comb begin
    address_frame = 1'b0;
    case (mode)
      MODE_SHIFT: begin
        address_frame = 1'b0;
      end
      MODE_UART8: begin
        address_frame = frame_stop_ok_in;
      end
      MODE_UART9_FIX, MODE_UART9_VAR: begin
        address_frame = frame_ninth_in;
      end
      default: begin
        address_frame = 1'b0;
      end
    endcase
  end

  // A frame is taken only while receive is on and software has cleared rx done for the
  // previous byte; with multiprocessor enable outside shift mode it must also hit an address.
  // Holding off while rx done is set keeps the last byte from being overwritten.
  always_comb begin
    accept = 1'b0;
    if (frame_valid_in && rx_enable_q && !rx_done_flag_q) begin
      if (!multiproc_enable_q || (mode == MODE_SHIFT)) begin
        accept = 1'b1;
      end else begin
        accept = address_frame && address_match;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Serial control register

  // Mode, enables and transmit ninth bit are plain software fields; bit 7 is the
  // first mode bit only while the framing check select is clear
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      serial_mode_bit0_q <= 1'b0;
      serial_mode_bit1_q <= 1'b0;
      multiproc_enable_q <= 1'b0;
      rx_enable_q <= 1'b0;
      tx_ninth_bit_q <= 1'b0;
    end else if (wr_control) begin
      if (!framing_check_select_q) begin
        serial_mode_bit0_q <= reg_wdata_in[MODE0_ERR_BIT];
      end
      serial_mode_bit1_q <= reg_wdata_in[MODE1_BIT];
      multiproc_enable_q <= reg_wdata_in[MPEN_BIT];
      rx_enable_q <= reg_wdata_in[REN_BIT];
      tx_ninth_bit_q <= reg_wdata_in[TX9_BIT];
    end
  end

  // Received ninth bit: the stop bit in 8-bit mode, the ninth data bit in the two 9-bit modes
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rx_ninth_bit_q <= 1'b0;
    end else if (accept && (mode != MODE_SHIFT)) begin
      if (mode == MODE_UART8) begin
        rx_ninth_bit_q <= frame_stop_ok_in;
      end else begin
        rx_ninth_bit_q <= frame_ninth_in;
      end
    end else if (wr_control) begin
      rx_ninth_bit_q <= reg_wdata_in[RX9_BIT];
    end
  end

  // Receive done: a hardware set beats a software clear in the same cycle
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rx_done_flag_q <= 1'b0;
    end else if (accept) begin
      rx_done_flag_q <= 1'b1;
    end else if (wr_control) begin
      rx_done_flag_q <= reg_wdata_in[RXDONE_BIT];
    end
  end

  // Transmit done, same set-wins arrangement
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tx_done_flag_q <= 1'b0;
    end else if (tx_complete_in) begin
      tx_done_flag_q <= 1'b1;
    end else if (wr_control) begin
      tx_done_flag_q <= reg_wdata_in[TXDONE_BIT];
    end
  end

  // Framing error is sticky: only software or reset clears it, never a good frame.
  // Software reaches it through bit 7 only while the framing check is selected.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      framing_error_flag_q <= 1'b0;
    end else if (framing_error_in && framing_check_select_q) begin
      framing_error_flag_q <= 1'b1;
    end else if (wr_control && framing_check_select_q) begin
      framing_error_flag_q <= reg_wdata_in[MODE0_ERR_BIT];
    end
  end

  // Framing check select, kept in a small control register of its own
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      framing_check_select_q <= 1'b0;
    end else if (wr_framing) begin
      framing_check_select_q <= reg_wdata_in[FRAMING_SEL_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Received byte and accept pulse

  // The byte is captured only for accepted frames, so a rejected address
  // leaves the previous byte in place for software
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rx_byte_q <= READ_IDLE;
    end else if (accept) begin
      rx_byte_q <= frame_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      frame_accept_q <= 1'b0;
    end else begin
      frame_accept_q <= accept;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read path

  // Bit 7 shows whichever field the framing check select currently exposes
  always_comb begin
    serial_control_rd = framing_check_select_q ? framing_error_flag_q : serial_mode_bit0_q;
  end

  // Unmapped addresses read as zero
  always_comb begin
    reg_rdata_d = READ_IDLE;
    case (reg_addr_in)
      SERIAL_CONTROL_OFS: begin
        reg_rdata_d[MODE0_ERR_BIT] = serial_control_rd;
        reg_rdata_d[MODE1_BIT] = serial_mode_bit1_q;
        reg_rdata_d[MPEN_BIT] = multiproc_enable_q;
        reg_rdata_d[REN_BIT] = rx_enable_q;
        reg_rdata_d[TX9_BIT] = tx_ninth_bit_q;
        reg_rdata_d[RX9_BIT] = rx_ninth_bit_q;
        reg_rdata_d[TXDONE_BIT] = tx_done_flag_q;
        reg_rdata_d[RXDONE_BIT] = rx_done_flag_q;
      end
      OWN_ADDRESS_OFS: begin
        reg_rdata_d = own_address_byte_q;
      end
      ADDRESS_MASK_OFS: begin
        reg_rdata_d = address_mask_byte_q;
      end
      FRAMING_CTRL_OFS: begin
        reg_rdata_d[FRAMING_SEL_BIT] = framing_check_select_q;
      end
      default: begin
        reg_rdata_d = READ_IDLE;
      end
    endcase
  end

  // Read data stand only in the cycle after the strobe and drop to zero after
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      reg_rdata_q <= READ_IDLE;
    end else if (reg_read_in) begin
      reg_rdata_q <= reg_rdata_d;
    end else begin
      reg_rdata_q <= READ_IDLE;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign reg_rdata_out = reg_rdata_q;
  assign serial_mode_bit0_out = serial_mode_bit0_q;
  assign serial_mode_bit1_out = serial_mode_bit1_q;
  assign multiproc_enable_out = multiproc_enable_q;
  assign rx_enable_out = rx_enable_q;
  assign tx_ninth_bit_out = tx_ninth_bit_q;
  assign framing_check_select_out = framing_check_select_q;
  assign rx_done_flag_out = rx_done_flag_q;
  assign tx_done_flag_out = tx_done_flag_q;
  assign framing_error_flag_out = framing_error_flag_q;
  assign frame_accept_out = frame_accept_q;
  assign rx_byte_out = rx_byte_q;

endmodule

`default_nettype wire

// File: dv/addr_filter_assertions.sv
// Port checker for the receive address filter
`timescale 1ns/10ps
`default_nettype none
module addr_filter_checker (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic frame_valid_in,
  input wire logic [7:0] frame_data_in,
  input wire logic frame_ninth_in,
  input wire logic tx_complete_in,
  input wire logic serial_mode_bit0_out,
  input wire logic serial_mode_bit1_out,
  input wire logic multiproc_enable_out,
  input wire logic rx_enable_out,
  input wire logic rx_done_flag_out,
  input wire logic tx_done_flag_out,
  input wire logic frame_accept_out,
  input wire logic [7:0] rx_byte_out
);
  logic [7:0] own_q;
  logic [7:0] mask_q;
  logic [7:0] bc;
  logic hit;
  logic gate;
  //////////////////////////////////////////////////////////////////////////
  // Shadow copies, since the address registers are not visible at the ports
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      own_q <= 8'h00;
      mask_q <= 8'h00;
    end else if (reg_write_in) begin
      if (reg_addr_in == 8'hA9) own_q <= reg_wdata_in;
      if (reg_addr_in == 8'hB9) mask_q <= reg_wdata_in;
    end
  end
  // Individual or broadcast match of the frame on the wire
  assign bc = own_q | mask_q;
  assign hit = (((frame_data_in ^ own_q) & mask_q) == 8'h00) || ((frame_data_in & bc) == bc);
  assign gate = frame_valid_in && rx_enable_out && !rx_done_flag_out;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  //////////////////////////////////////////////////////////////////////////
  rd_idle_a: assert property (!$past(reg_read_in) |-> reg_rdata_out == 8'h00)
    else $error("read data not idle");
  own_read_a: assert property (reg_read_in && reg_addr_in == 8'hA9 |=> reg_rdata_out == own_q)
    else $error("own address readback wrong");
  mask_read_a: assert property (reg_read_in && reg_addr_in == 8'hB9 |=> reg_rdata_out == mask_q)
    else $error("mask readback wrong");
  addr_match_a: assert property (gate && multiproc_enable_out && serial_mode_bit0_out
    && frame_ninth_in |=> frame_accept_out == $past(hit)) else $error("match decision wrong");
  data_frame_a: assert property (gate && multiproc_enable_out && serial_mode_bit0_out
    && !frame_ninth_in |=> !frame_accept_out) else $error("data frame accepted");
  shift_mode_a: assert property (gate && !serial_mode_bit0_out && !serial_mode_bit1_out
    |=> frame_accept_out) else $error("shift mode frame refused");
  plain_rx_a: assert property (gate && !multiproc_enable_out
    |=> frame_accept_out && rx_byte_out == $past(frame_data_in)) else $error("frame lost");
  busy_drop_a: assert property (frame_valid_in && rx_done_flag_out |=> !frame_accept_out)
    else $error("frame taken while flag set");
  accept_pulse_a: assert property (frame_accept_out |-> rx_done_flag_out ##1 !frame_accept_out)
    else $error("accept pulse wrong");
  tx_done_a: assert property (tx_complete_in |=> tx_done_flag_out)
    else $error("transmit flag not set");
endmodule
bind uart_slave_address_filter addr_filter_checker u_addr_filter_checker (.*);
`default_nettype wire

// File: dv/remote_master_model.sv
// Remote serial master handing finished frames to the filter
`timescale 1ns/10ps
`default_nettype none
module remote_master_model (
  input wire logic clk_in,
  output logic frame_valid_out,
  output logic [7:0] frame_data_out,
  output logic frame_ninth_out,
  output logic frame_stop_ok_out
);
  initial begin
    frame_valid_out = 1'b0;
    frame_data_out = 8'h00;
    frame_ninth_out = 1'b0;
    frame_stop_ok_out = 1'b0;
  end
  // One frame a call; the address picks one, some or all slaves
  task automatic send(input logic [7:0] d, input logic n, input logic s);
    @(posedge clk_in);
    frame_valid_out <= 1'b1;
    frame_data_out <= d;
    frame_ninth_out <= n;
    frame_stop_ok_out <= s;
    @(posedge clk_in);
    // Released lines show the inverse so a stale value never passes for fresh
    frame_valid_out <= 1'b0;
    frame_data_out <= ~d;
    frame_ninth_out <= ~n;
    frame_stop_ok_out <= ~s;
  endtask
endmodule
`default_nettype wire

// File: dv/uart_slave_address_filter_bench.sv
// Self-checking bench of the receive address filter
`timescale 1ns/10ps
`default_nettype none
module uart_slave_address_filter_bench;
  import addr_filter_pkg::*;
  logic clk_in, nrst_in, wr_s, rd_s, fv, fn, fs, ferr_p, tx_p;
  logic fcs, txd, fef, acc, tx9;
  logic [7:0] addr, wdata, rdata, fd, rxb, cfg, last;
  int n_mismatch;
  int n_compared;
  // Own, mask, address, expected acceptance
  // Rows ten to fourteen give the usual all-ones broadcast pattern
  localparam logic [31:0] TBL [14] = '{32'h56FC5501, 32'h56FC5A00, 32'h56FCFE01,
    32'hF1FAF001, 32'hF1FAF300, 32'hF1FAFB01, 32'hF3F9F301, 32'hF3F9F000,
    32'hF3F9FB01, 32'hF2FDF001, 32'hF2FDF100, 32'hF2FDFB00, 32'h56FF5601, 32'h56FF5700};
  uart_slave_address_filter u_uart_slave_address_filter (.clk_in(clk_in), .nrst_in(nrst_in),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_write_in(wr_s), .reg_read_in(rd_s),
    .reg_rdata_out(rdata), .frame_valid_in(fv), .frame_data_in(fd), .frame_ninth_in(fn),
    .frame_stop_ok_in(fs), .framing_error_in(ferr_p), .tx_complete_in(tx_p),
    .serial_mode_bit0_out(), .serial_mode_bit1_out(), .multiproc_enable_out(),
    .rx_enable_out(), .tx_ninth_bit_out(tx9), .framing_check_select_out(fcs),
    .rx_done_flag_out(), .tx_done_flag_out(txd), .framing_error_flag_out(fef),
    .frame_accept_out(acc), .rx_byte_out(rxb));
  remote_master_model u_remote_master_model (.clk_in(clk_in), .frame_valid_out(fv),
    .frame_data_out(fd), .frame_ninth_out(fn), .frame_stop_ok_out(fs));
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk_in);
    wr_s <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_in);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk_in);
    rd_s <= 1'b0;
    #1;
    chk(rdata, e);
  endtask
  task automatic cfgw(input logic [7:0] v);
    cfg = v;
    wr(8'h98, v);
  endtask
  // A refused frame must leave the received byte untouched
  task automatic frame(input logic [7:0] d, input logic n, input logic s, input logic e);
    u_remote_master_model.send(d, n, s);
    #1;
    chk({7'h00, acc}, {7'h00, e});
    chk(rxb, e ? d : last);
    if (e) last = d;
    wr(8'h98, cfg);
  endtask
  task automatic end_sim;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd(8'hA9, 8'h00);
    rd(8'hB9, 8'h00);
    rd(8'h98, 8'h00);
    cfgw(8'hF8);
    u_remote_master_model.send(8'h3C, 1'b1, 1'b1);
    rd(8'h98, 8'hFD);
    chk({7'h00, tx9}, 8'h01);
    @(posedge clk_in);
    tx_p <= 1'b1;
    @(posedge clk_in);
    tx_p <= 1'b0;
    rd(8'h98, 8'hFF);
    last = 8'h3C;
    cfgw(8'hF0);
  endtask
  task automatic t_regs;
    wr(8'hA9, 8'h56);
    wr(8'hB9, 8'hFC);
    wr(8'h55, 8'hAA);
    rd(8'hA9, 8'h56);
    rd(8'hB9, 8'hFC);
    rd(8'h55, 8'h00);
    // Reset in mid-run must clear values that are not zero
    @(posedge clk_in);
    nrst_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    nrst_in <= 1'b1;
    rd(8'hA9, 8'h00);
    rd(8'hB9, 8'h00);
    wr(8'h98, cfg);
    last = 8'h00;
  endtask
  task automatic t_match;
    foreach (TBL[i]) begin
      wr(8'hA9, TBL[i][31:24]);
      wr(8'hB9, TBL[i][23:16]);
      frame(TBL[i][15:8], 1'b1, 1'b1, TBL[i][0]);
    end
  endtask
  // Second frame arrives while the first is still unread
  task automatic t_busy;
    u_remote_master_model.send(8'h56, 1'b1, 1'b1);
    u_remote_master_model.send(8'hFF, 1'b1, 1'b1);
    #1;
    chk(rxb, 8'h56);
    last = 8'h56;
    wr(8'h98, cfg);
  endtask
  task automatic t_modes;
    frame(8'h56, 1'b0, 1'b1, 1'b0);
    cfgw(8'h70);
    frame(8'h56, 1'b1, 1'b0, 1'b0);
    frame(8'h56, 1'b0, 1'b1, 1'b1);
    frame(8'h57, 1'b1, 1'b1, 1'b0);
    cfgw(8'h30);
    frame(8'h11, 1'b0, 1'b0, 1'b1);
    cfgw(8'hD0);
    frame(8'h57, 1'b0, 1'b0, 1'b1);
    cfgw(8'hE0);
    frame(8'h56, 1'b1, 1'b1, 1'b0);
    cfgw(8'hB0);
    frame(8'h56, 1'b1, 1'b0, 1'b1);
  endtask
  task automatic t_flags;
    wr(8'hC1, 8'h01);
    // Hardware sets land in the same cycle as a write that clears transmit done: the sets must win
    @(posedge clk_in);
    ferr_p <= 1'b1;
    tx_p <= 1'b1;
    addr <= 8'h98;
    wdata <= cfg;
    wr_s <= 1'b1;
    @(posedge clk_in);
    ferr_p <= 1'b0;
    tx_p <= 1'b0;
    wr_s <= 1'b0;
    #1;
    chk({6'h00, fcs, fef}, 8'h03);
    chk({7'h00, txd}, 8'h01);
    rd(8'h98, 8'hB2);
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  // Whole run is a few hundred cycles; this is far beyond it
  initial begin
    #200000;
    n_mismatch++;
    end_sim;
  end
  initial begin
    {nrst_in, wr_s, rd_s, ferr_p, tx_p, addr, wdata, cfg, last} = '0;
    repeat (16) @(posedge clk_in);
    nrst_in <= 1'b1;
    t_reset;
    t_regs;
    t_match;
    t_busy;
    t_modes;
    t_flags;
    end_sim;
  end
endmodule
`default_nettype wire
